// file: hdl/srcs_pkg.sv
// constants shared by the serial receive control and status block
// Operation
// RL1: asynchronous mode: continuous receive enable at 0 turns the receiver off
// RL2: synchronous mode: continuous enable keeps receiving and overrides single
// RL3: 9-bit address mode: only ninth-bit-set characters are buffered and flagged
// RL4: address detect off: every character is buffered, ninth bit kept
// RL5: 8-bit asynchronous mode ignores the address detect enable
// RL6: framing flag follows the buffered character, updated after buffer reads
// RL7: overrun flag is set on overrun, cleared by clearing continuous enable
// RL8: ninth received bit is readable at control bit 0
// RL9: firmware checks any parity in the ninth bit; hardware only stores it
// RL10: unimplemented control bits read as zero and ignore writes
// RL11: character completing while buffer full flags overrun, halts reception
package srcs_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_CFG = 8'h0c;
  localparam int CTRL_CONT_EN = 4;
  localparam int CTRL_ADDR_DET = 3;
  localparam int CTRL_FRAME_ERR = 2;
  localparam int CTRL_OVERRUN = 1;
  localparam int CTRL_NINTH = 0;
  localparam int CFG_SYNC = 0;
  localparam int CFG_NINE_BIT = 1;
  localparam int CFG_SINGLE_EN = 2;
  localparam int CFG_DIV_LSB = 16;
  localparam int STAT_VALID = 0;
  localparam int STAT_FULL = 1;
  localparam logic [15:0] DIV_RESET = 16'h000c;
  localparam int FIFO_DEPTH = 16;
  localparam int WORD_W = 10;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] OVERSAMPLE_MID = 4'h7;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } srcs_rx_state_type;
endpackage : srcs_pkg

// file: hdl/srcs_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module srcs_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic push, pop;

  assign in_ready = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = CW'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = CW'(count - 1'b1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  a_fifo_no_overflow: assert property (@(posedge pclk) disable iff (!presetn)
    count == CW'(DEPTH) |=> count <= CW'(DEPTH)) else $error("fifo overflow");
endmodule : srcs_fifo

// file: hdl/srcs_rx_shift.sv
// character assembler for asynchronous and synchronous reception
`timescale 1ns/1ps
module srcs_rx_shift (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic sync_mode,
  input wire logic nine_bit,
  input wire logic tick,
  input wire logic rx_level,
  input wire logic sclk_rise,
  output logic done,
  output logic [8:0] word,
  output logic frame_err
);
  import srcs_pkg::*;
  srcs_rx_state_type state, next_state;
  logic [3:0] tick_cnt, next_tick_cnt, bit_cnt, next_bit_cnt, nbits;
  logic [8:0] shift, next_shift, next_word, incoming;
  logic next_done, next_frame_err;

  // 8-bit characters sit one place high after shifting in lsb first
  function automatic logic [8:0] align(input logic [8:0] s, input logic nine);
    align = nine ? s : {1'b0, s[8:1]};
  endfunction : align

  always_comb begin
    next_state = state;
    next_tick_cnt = tick_cnt;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_word = word;
    next_frame_err = frame_err;
    next_done = 1'b0;
    nbits = nine_bit ? 4'h9 : 4'h8;
    incoming = {rx_level, shift[8:1]};
    if (!enable) begin
      next_state = RX_IDLE;
      next_bit_cnt = '0;
    end else if (sync_mode) begin
      if (sclk_rise) begin
        next_shift = incoming;
        next_bit_cnt = bit_cnt + 4'h1;
        if (bit_cnt + 4'h1 == nbits) begin
          next_done = 1'b1;
          next_word = align(incoming, nine_bit);
          next_frame_err = 1'b0;
          next_bit_cnt = '0;
        end
      end
    end else begin
      unique case (state)
        RX_IDLE: begin
          next_tick_cnt = '0;
          next_bit_cnt = '0;
          if (!rx_level) begin
            next_state = RX_START;
          end
        end
        RX_START: begin
          if (tick) begin
            next_tick_cnt = tick_cnt + 4'h1;
            if (tick_cnt == OVERSAMPLE_MID) begin
              next_tick_cnt = '0;
              next_state = rx_level ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            next_tick_cnt = tick_cnt + 4'h1;
            if (tick_cnt == OVERSAMPLE_LAST) begin
              next_shift = incoming;
              next_bit_cnt = bit_cnt + 4'h1;
              if (bit_cnt + 4'h1 == nbits) begin
                next_state = RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (tick) begin
            next_tick_cnt = tick_cnt + 4'h1;
            if (tick_cnt == OVERSAMPLE_LAST) begin
              next_done = 1'b1;
              next_word = align(shift, nine_bit);
              next_frame_err = !rx_level;
              next_state = RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RX_IDLE;
      tick_cnt <= '0;
      bit_cnt <= '0;
      shift <= '0;
      word <= '0;
      frame_err <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      word <= next_word;
      frame_err <= next_frame_err;
      done <= next_done;
    end
  end
endmodule : srcs_rx_shift

// file: hdl/srcs_top.sv
// apb register file, receive control, error flags and buffering
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module srcs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_pin,
  input wire logic sclk_pin,
  output logic receive_interrupt_flag
);
  import srcs_pkg::*;

  logic rx_meta, rx_sync, sclk_meta, sclk_sync, sclk_prev;
  logic continuous_receive_enable, next_continuous_receive_enable;
  logic single_receive_enable, next_single_receive_enable;
  logic address_detect_enable, next_address_detect_enable;
  logic nine_bit_receive_select, next_nine_bit_receive_select;
  logic sync_mode, next_sync_mode;
  logic [15:0] divisor, next_divisor, baud_cnt, next_baud_cnt;
  logic overrun_error_flag, next_overrun_error_flag;
  logic framing_error_flag, next_framing_error_flag;
  logic received_ninth_bit, next_received_ninth_bit;
  logic need_load, next_need_load;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic tick, sclk_rise, rx_enable, char_done, char_framing_error_flag;
  logic [8:0] char_word;
  logic addr_mode, accept, push, overrun_set;
  logic fifo_in_ready, fifo_out_valid, pop, load_head;
  logic [WORD_W-1:0] fifo_out;
  logic setup_rd, acc_wr, acc_rd;

  // pin inputs come from another domain and pass two flops first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_prev <= 1'b0;
    end else begin
      rx_meta <= rx_pin;
      rx_sync <= rx_meta;
      sclk_meta <= sclk_pin;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
    end
  end

  assign sclk_rise = sclk_sync && !sclk_prev;
  assign tick = (baud_cnt == '0);
  assign pready = 1'b1;
  assign setup_rd = psel && !penable && !pwrite;
  assign acc_wr = psel && penable && pwrite;
  assign acc_rd = psel && penable && !pwrite;

  // overrun stalls the receiver so no half-lost character follows it
  always_comb begin
    if (!sync_mode) begin
      rx_enable = continuous_receive_enable && !overrun_error_flag; // RL1 RL11
    end else begin
      rx_enable = (continuous_receive_enable || single_receive_enable)
        && !overrun_error_flag; // RL2 RL11
    end
  end

  assign addr_mode = !sync_mode && nine_bit_receive_select
    && address_detect_enable; // RL5
  assign accept = !addr_mode || char_word[8]; // RL3 RL4
  assign push = char_done && accept && fifo_in_ready;
  assign overrun_set = char_done && accept && !fifo_in_ready; // RL11
  assign pop = acc_rd && (paddr == ADDR_DATA) && fifo_out_valid;
  assign load_head = need_load && fifo_out_valid;
  assign receive_interrupt_flag = fifo_out_valid; // RL3

  srcs_rx_shift u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .enable(rx_enable),
    .sync_mode(sync_mode),
    .nine_bit(nine_bit_receive_select),
    .tick(tick),
    .rx_level(rx_sync),
    .sclk_rise(sclk_rise),
    .done(char_done),
    .word(char_word),
    .frame_err(char_framing_error_flag)
  );

  // the error and ninth bit travel with each character
  srcs_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(char_done && accept),
    .in_ready(fifo_in_ready),
    .in_data({char_framing_error_flag, char_word}),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out)
  );

  always_comb begin
    next_continuous_receive_enable = continuous_receive_enable;
    next_address_detect_enable = address_detect_enable;
    next_single_receive_enable = single_receive_enable;
    next_nine_bit_receive_select = nine_bit_receive_select;
    next_sync_mode = sync_mode;
    next_divisor = divisor;
    next_overrun_error_flag = overrun_error_flag;
    next_framing_error_flag = framing_error_flag;
    next_received_ninth_bit = received_ninth_bit;
    next_need_load = need_load;
    next_prdata = prdata;
    next_pslverr = pslverr;
    next_baud_cnt = tick ? (divisor - 16'h0001) : (baud_cnt - 16'h0001);
    if (divisor == '0) begin
      next_baud_cnt = '0;
    end
    if (acc_wr && paddr == ADDR_CTRL) begin
      // status bits and the unused upper bits take no write
      next_continuous_receive_enable = pwdata[CTRL_CONT_EN]; // RL10
      next_address_detect_enable = pwdata[CTRL_ADDR_DET];
      if (!pwdata[CTRL_CONT_EN]) begin
        next_overrun_error_flag = 1'b0; // RL7
      end
    end
    if (acc_wr && paddr == ADDR_CFG) begin
      next_sync_mode = pwdata[CFG_SYNC];
      next_nine_bit_receive_select = pwdata[CFG_NINE_BIT];
      next_single_receive_enable = pwdata[CFG_SINGLE_EN];
      next_divisor = pwdata[CFG_DIV_LSB +: 16];
    end
    // single receive ends after one character unless continuous holds
    if (sync_mode && char_done && !continuous_receive_enable) begin
      next_single_receive_enable = 1'b0; // RL2
    end
    if (overrun_set && rx_enable) begin
      next_overrun_error_flag = 1'b1; // RL11
    end
    if (pop) begin
      next_need_load = 1'b1;
    end else if (load_head) begin
      next_framing_error_flag = fifo_out[WORD_W-1]; // RL6
      next_received_ninth_bit = fifo_out[8]; // RL8 RL9
      next_need_load = 1'b0;
    end
    if (setup_rd || (psel && !penable)) begin
      next_prdata = '0;
      next_pslverr = 1'b0;
      if (!pwrite) begin
        unique case (paddr)
          ADDR_CTRL: begin
            next_prdata[CTRL_CONT_EN] = continuous_receive_enable;
            next_prdata[CTRL_ADDR_DET] = address_detect_enable;
            next_prdata[CTRL_FRAME_ERR] = framing_error_flag;
            next_prdata[CTRL_OVERRUN] = overrun_error_flag;
            next_prdata[CTRL_NINTH] = received_ninth_bit; // RL8 RL10
          end
          ADDR_DATA: begin
            next_prdata[7:0] = fifo_out[7:0];
          end
          ADDR_STAT: begin
            next_prdata[STAT_VALID] = fifo_out_valid;
            next_prdata[STAT_FULL] = !fifo_in_ready;
          end
          ADDR_CFG: begin
            next_prdata[CFG_SYNC] = sync_mode;
            next_prdata[CFG_NINE_BIT] = nine_bit_receive_select;
            next_prdata[CFG_SINGLE_EN] = single_receive_enable;
            next_prdata[CFG_DIV_LSB +: 16] = divisor;
          end
          default: begin
            next_pslverr = 1'b1;
          end
        endcase
      end else begin
        next_pslverr = !(paddr == ADDR_CTRL || paddr == ADDR_CFG);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      continuous_receive_enable <= 1'b0;
      address_detect_enable <= 1'b0;
      single_receive_enable <= 1'b0;
      nine_bit_receive_select <= 1'b0;
      sync_mode <= 1'b0;
      divisor <= DIV_RESET;
      baud_cnt <= '0;
      overrun_error_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      received_ninth_bit <= 1'b0;
      need_load <= 1'b1;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      continuous_receive_enable <= next_continuous_receive_enable;
      address_detect_enable <= next_address_detect_enable;
      single_receive_enable <= next_single_receive_enable;
      nine_bit_receive_select <= next_nine_bit_receive_select;
      sync_mode <= next_sync_mode;
      divisor <= next_divisor;
      baud_cnt <= next_baud_cnt;
      overrun_error_flag <= next_overrun_error_flag;
      framing_error_flag <= next_framing_error_flag;
      received_ninth_bit <= next_received_ninth_bit;
      need_load <= next_need_load;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  sequence s_ctrl_setup;
    psel && !penable && !pwrite && paddr == ADDR_CTRL;
  endsequence

  sequence s_ctrl_access;
    psel && penable && !pwrite;
  endsequence

  a_async_rx_off: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    !sync_mode && !continuous_receive_enable |-> !rx_enable ##1 !char_done)
    else $error("receiver on with continuous enable clear");

  a_continuous_receive_enable_over_single: assert property (@(posedge pclk) // RL2
    disable iff (!presetn)
    sync_mode && continuous_receive_enable && !overrun_error_flag
    && char_done && fifo_in_ready && !(acc_wr && paddr == ADDR_CTRL)
    |=> rx_enable)
    else $error("continuous reception stopped");

  a_addr_filter: assert property (@(posedge pclk) disable iff (!presetn) // RL3
    char_done && addr_mode && !char_word[8] |=> $stable(u_fifo.count)
    || $past(pop))
    else $error("address character filter let data through");

  a_accept_all: assert property (@(posedge pclk) disable iff (!presetn) // RL4
    char_done && !addr_mode && fifo_in_ready |-> push)
    else $error("character dropped with detection off");

  a_address_detect_enable_ignored: assert property (@(posedge pclk) disable iff (!presetn) // RL5
    !sync_mode && !nine_bit_receive_select |-> accept)
    else $error("address detect acted in 8-bit mode");

  a_framing_error_flag_tracks: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    $changed(framing_error_flag) |-> $past(load_head, 1))
    else $error("framing flag changed without a buffer load");

  a_overrun_error_flag_clear: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    acc_wr && paddr == ADDR_CTRL && !pwdata[CTRL_CONT_EN]
    && !single_receive_enable && !(overrun_set && rx_enable)
    |=> !overrun_error_flag[*2])
    else $error("overrun flag not cleared");

  a_ninth_read: assert property (@(posedge pclk) disable iff (!presetn) // RL8
    s_ctrl_setup ##1 s_ctrl_access |->
    prdata[CTRL_NINTH] == $past(received_ninth_bit))
    else $error("ninth bit misread");

  a_unused_zero: assert property (@(posedge pclk) disable iff (!presetn) // RL10
    s_ctrl_setup ##1 s_ctrl_access |-> prdata[31:5] == '0)
    else $error("unimplemented control bits not zero");

  a_overrun_set: assert property (@(posedge pclk) disable iff (!presetn) // RL11
    overrun_set && rx_enable |=> overrun_error_flag && !rx_enable)
    else $error("overrun not flagged or reception not halted");

  // while the overrun stands no character may complete
  a_overrun_hold: assert property (@(posedge pclk) // RL11
    disable iff (!presetn)
    overrun_error_flag |-> !rx_enable ##1 !char_done)
    else $error("reception went on during overrun");

  sequence s_single_char;
    sync_mode && single_receive_enable && !continuous_receive_enable
    && char_done && !acc_wr;
  endsequence

  // single reception ends itself after one character
  a_single_stops: assert property (@(posedge pclk) // RL2
    disable iff (!presetn)
    s_single_char |=> !single_receive_enable && !rx_enable)
    else $error("single reception kept running");

  // the head's flags must be the ones stored with that character
  a_ninth_load: assert property (@(posedge pclk) disable iff (!presetn) // RL8
    load_head && !pop |=> received_ninth_bit == $past(fifo_out[8])
    && framing_error_flag == $past(fifo_out[WORD_W-1]))
    else $error("head flags not loaded with the character");

  // a dropped address-mode character must leave the flag alone
  a_drop_no_flag: assert property (@(posedge pclk) // RL3
    disable iff (!presetn)
    char_done && addr_mode && !char_word[8] && !fifo_out_valid
    |=> !receive_interrupt_flag)
    else $error("dropped character raised the receive flag");

  a_status_no_write: assert property (@(posedge pclk) // RL10
    disable iff (!presetn)
    acc_wr && paddr == ADDR_CTRL && !load_head
    |=> $stable(framing_error_flag) && $stable(received_ninth_bit))
    else $error("status bit took a write");
endmodule : srcs_top

// file: dv/srcs_tx_model.sv
// remote transmitter model driving the receive line and sync bit clock
`timescale 1ns/1ps
module srcs_tx_model #(
  parameter int BIT_CYC = 16
) (
  input wire logic pclk,
  output logic tx_line,
  output logic sclk_line
);
  initial begin
    tx_line = 1'b1;
    sclk_line = 1'b0;
  end
  // start, lsb first data, stop; stop_ok low forces a framing fault
  task automatic send_async(input logic [8:0] d, input int nbits,
                            input logic stop_ok);
    for (int i = 0; i < nbits + 2; i++) begin
      if (i == 0) begin
        tx_line <= 1'b0;
      end else if (i > nbits) begin
        tx_line <= stop_ok;
      end else begin
        tx_line <= d[i-1];
      end
      repeat (BIT_CYC) @(posedge pclk);
    end
    tx_line <= 1'b1;
  endtask : send_async
  // bit clock stands low outside frames; data is set while it is low
  task automatic send_sync(input logic [8:0] d, input int nbits);
    for (int i = 0; i < nbits; i++) begin
      tx_line <= d[i];
      repeat (8) @(posedge pclk);
      sclk_line <= 1'b1;
      repeat (8) @(posedge pclk);
      sclk_line <= 1'b0;
    end
    repeat (8) @(posedge pclk);
    // released line must not keep showing the last bit
    tx_line <= ~d[nbits-1];
  endtask : send_sync
endmodule : srcs_tx_model

// file: dv/serial_receive_control_status_test.sv
// self-checking bench for the serial receive control and status block
`timescale 1ns/1ps
module serial_receive_control_status_test;
  import srcs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic rx_pin, sclk_pin, receive_interrupt_flag;
  int miscompares, checked;
  srcs_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_pin(rx_pin), .sclk_pin(sclk_pin),
    .receive_interrupt_flag(receive_interrupt_flag));
  srcs_tx_model far (.pclk(pclk), .tx_line(rx_pin), .sclk_line(sclk_pin));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input string name, input logic [7:0] a,
                    input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(name, r, exp);
  endtask : rd
  task automatic rx(input logic [8:0] d, input int nb, input logic ok);
    far.send_async(d, nb, ok);
    repeat (4) @(posedge pclk);
  endtask : rx
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    rd("ctrl reset", ADDR_CTRL, 32'h0000_0000);
    rd("cfg reset", ADDR_CFG, 32'h000c_0000);
    rd("stat reset", ADDR_STAT, 32'h0000_0000);
    wr(ADDR_CTRL, 32'hffff_ffff);
    rd("ctrl spare bits", ADDR_CTRL, 32'h0000_0018);
    wr(ADDR_CTRL, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000, r, e);
    chk("unmapped err", 32'(e), 32'h0000_0001);
    chk("unmapped data", r, 32'h0000_0000);
  endtask : t_regs
  task automatic t_async;
    wr(ADDR_CFG, 32'h0000_0000);
    rx(9'h011, 8, 1'b1);
    rd("off stat", ADDR_STAT, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0010);
    rx(9'h00f, 8, 1'b0);
    rd("framing_error_flag set", ADDR_CTRL, 32'h0000_0014);
    rd("framing_error_flag data", ADDR_DATA, 32'h0000_000f);
    rx(9'h021, 8, 1'b1);
    rd("framing_error_flag next", ADDR_CTRL, 32'h0000_0010);
    rd("good data", ADDR_DATA, 32'h0000_0021);
    wr(ADDR_CTRL, 32'h0000_0018);
    rx(9'h033, 8, 1'b1);
    rd("address_detect_enable 8bit", ADDR_DATA, 32'h0000_0033);
  endtask : t_async
  task automatic t_nine;
    logic [7:0] v;
    wr(ADDR_CFG, 32'h0000_0002);
    rx(9'h0aa, 9, 1'b1);
    chk("drop flag", 32'(receive_interrupt_flag), 32'h0000_0000);
    rd("drop stat", ADDR_STAT, 32'h0000_0000);
    rx(9'h1a5, 9, 1'b1);
    chk("addr flag", 32'(receive_interrupt_flag), 32'h0000_0001);
    rd("addr ninth", ADDR_CTRL, 32'h0000_0019);
    rd("addr data", ADDR_DATA, 32'h0000_00a5);
    wr(ADDR_CTRL, 32'h0000_0010);
    v = 8'h5b;
    // firmware-side parity in the ninth bit; odd count so the bit is 1
    rx({^v, v}, 9, 1'b1);
    rd("par ninth", ADDR_CTRL, 32'h0000_0011);
    rd("par data", ADDR_DATA, 32'(v));
  endtask : t_nine
  task automatic t_overrun;
    wr(ADDR_CFG, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0010);
    for (int i = 0; i < FIFO_DEPTH + 2; i++) begin
      rx(9'(i + 1), 8, 1'b1);
    end
    rd("ovr stat", ADDR_STAT, 32'h0000_0003);
    rd("ovr flag", ADDR_CTRL, 32'h0000_0012);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      rd("drain", ADDR_DATA, 32'(i + 1));
    end
    rd("drain stat", ADDR_STAT, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0000);
    rd("ovr clear", ADDR_CTRL, 32'h0000_0000);
  endtask : t_overrun
  task automatic t_sync;
    wr(ADDR_CFG, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0010);
    far.send_sync(9'h03c, 8);
    far.send_sync(9'h0e1, 8);
    rd("cont 1", ADDR_DATA, 32'h0000_003c);
    rd("cont 2", ADDR_DATA, 32'h0000_00e1);
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_CFG, 32'h0000_0005);
    far.send_sync(9'h0c3, 8);
    rd("single", ADDR_DATA, 32'h0000_00c3);
    rd("single off", ADDR_CFG, 32'h0000_0001);
    far.send_sync(9'h099, 8);
    rd("sync off", ADDR_STAT, 32'h0000_0000);
  endtask : t_sync
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    miscompares = 0;
    checked = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_async();
    t_nine();
    t_overrun();
    t_sync();
    final_report();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    miscompares++;
    final_report();
  end
endmodule : serial_receive_control_status_test
